// >>> core/pfc_consts.vh
// constants for the program flash access controller
`ifndef PFC_CONSTS_VH
`define PFC_CONSTS_VH
// apb byte addresses
`define PFC_OFF_CTRL 12'h000
`define PFC_OFF_KEY 12'h004
`define PFC_OFF_ADDR 12'h008
`define PFC_OFF_DATA 12'h00c
// control register fields
`define PFC_B_RD 0
`define PFC_B_WR 1
`define PFC_B_ERASE 2
`define PFC_B_LATCH 3
`define PFC_B_MODIFY 4
`define PFC_B_REGION 5
`define PFC_B_FAULT 6
`define PFC_B_DONE 7
`define PFC_B_IRQEN 8
`define PFC_B_BUSY 9
// unlock keys
`define PFC_KEY1 8'h55
`define PFC_KEY2 8'haa
// reset and blank values
`define PFC_BLANK 14'h3fff
`define PFC_ADDR_RST 15'h0000
`define PFC_DATA_RST 14'h0000
// latch row geometry
`define PFC_LATCHES 32
`define PFC_LAST_LATCH 5'h1f
// pointer values that land on the indirect window registers
`define PFC_WIN0 16'h0000
`define PFC_WIN1 16'h0001
`endif

// >>> core/pfc_ctrl.v
// program flash access controller: indirect reads and register interface
//
// Function
// - pointer high byte top bit set steers indirect loads to flash address
// - pointer aimed at an indirect window register reads back zero
// - indirect read stalls one cycle and returns one byte
// - indirect stores never program or erase flash
// - read trigger stalls, loads data pair next cycle, then self-clears
// - data pair holds until next read or a software write
// - region bit picks main memory or identifier/configuration space
// - writes or erases to protected targets are blocked
// - erase, program and latch-load operations start only after keys 55h, AAh then program trigger
// - interrupted or non-consecutive unlock steps perform nothing
// - execution stalls until erase or program finishes
// - erase needs erase-select and modify-allow; erases one whole row
// - erase of protected row clears trigger and skips erase
// - erase completion sets completion flag; interrupt when allowed
// - erase leaves latches and modify-allow unchanged
// - programming never erases first; it only clears bits
// - upper ten address bits pick row, low five bits pick latch
// - every latch returns to 3FFF after a program operation
// - latch-only set loads a latch; clear programs the whole row
// - unloaded latches stay blank
// - one program writes at most the 32 latches
// - fault flag set on protected trigger, reset mid-write, broken unlock
// - config-space read outside valid ranges clears the data pair
`timescale 1ns/1ns
`include "pfc_consts.vh"

module pfc_ctrl (
	input wire clock, // 100 MHz instruction clock
	input wire reset_n, // asynchronous reset, active low
	input wire psel, // apb select
	input wire penable, // apb access phase
	input wire pwrite, // apb direction
	input wire [11:0] paddr, // apb byte address
	input wire [31:0] pwdata, // apb write data
	output wire [31:0] prdata, // apb read data
	output wire pready, // apb ready
	output wire pslverr, // apb error on unmapped address
	input wire ind_req, // indirect load request pulse
	input wire ind_store, // request is an indirect store
	input wire [15:0] ind_ptr, // pointer pair
	output reg [7:0] ind_data_ff, // indirect read byte
	output reg ind_done_ff, // indirect read answer pulse
	output wire cpu_stall, // holds cpu execution
	input wire unlock_break, // interrupt or halt intervened
	input wire pfm_protect, // main memory write protection
	input wire abort_seen, // flash saw a reset during self-write
	output reg [15:0] fl_addr_ff, // region and word address to flash
	output reg fl_rd_ff, // flash read pulse
	output reg fl_erase_ff, // flash row erase pulse
	output reg fl_prog_ff, // flash word program pulse
	output reg [13:0] fl_wdata_ff, // flash program data
	input wire [13:0] fl_rdata, // flash read word, same cycle as read pulse
	input wire fl_busy, // flash timer running
	output wire irq // completion interrupt
);

	// ****************************************
	// decode helpers
	// ****************************************
	function cfg_writable;
		input [14:0] a;
		begin
			cfg_writable = (a <= 15'h0003) || (a >= 15'h0007 && a <= 15'h000b);
		end
	endfunction

	function cfg_readable;
		input [14:0] a;
		begin
			cfg_readable = (a <= 15'h0003) || (a >= 15'h0005 && a <= 15'h000b) ||
				(a >= 15'h0100 && a <= 15'h02ff);
		end
	endfunction

	function win_hit;
		input [15:0] p;
		begin
			win_hit = (p == `PFC_WIN0) || (p == `PFC_WIN1);
		end
	endfunction

	// ****************************************
	// state and registers
	// ****************************************
	localparam ST_IDLE = 3'd0;
	localparam ST_RD = 3'd1;
	localparam ST_IND = 3'd2;
	localparam ST_ERASE = 3'd3;
	localparam ST_PROG = 3'd4;
	localparam ST_WAIT = 3'd5;
	localparam KY_NONE = 2'd0;
	localparam KY_ONE = 2'd1;
	localparam KY_ARMED = 2'd2;

	reg [2:0] state_ff;
	reg [2:0] nxt_state;
	reg [1:0] key_ff;
	reg [1:0] nxt_key;
	reg rd_ff, wr_ff, erase_sel_ff, latch_sel_ff, modify_ff, region_ff;
	reg fault_ff, done_ff, irq_en_ff;
	reg [14:0] addr_ff;
	reg [13:0] data_ff;
	reg [4:0] idx_ff;
	reg ind_win_ff;
	reg boot_ff;
	reg latch_clear;
	reg latch_load;
	reg [13:0] latch_ff [0:`PFC_LATCHES-1];

	wire acc = psel && penable;
	wire wr_acc = acc && pwrite;
	wire idle = (state_ff == ST_IDLE);
	wire hit_ctrl = (paddr == `PFC_OFF_CTRL);
	wire hit_key = (paddr == `PFC_OFF_KEY);
	wire hit_addr = (paddr == `PFC_OFF_ADDR);
	wire hit_data = (paddr == `PFC_OFF_DATA);
	wire mapped = hit_ctrl || hit_key || hit_addr || hit_data;
	wire sw_ctrl = wr_acc && hit_ctrl && idle;
	wire trig_rd = sw_ctrl && pwdata[`PFC_B_RD] && !rd_ff;
	wire trig_wr = sw_ctrl && pwdata[`PFC_B_WR] && !wr_ff;
	wire protect = region_ff ? !cfg_writable(addr_ff) : pfm_protect;
	wire [9:0] row = addr_ff[14:5];

	assign pready = 1'b1;
	assign pslverr = acc && !mapped;
	assign cpu_stall = !idle;
	assign irq = done_ff && irq_en_ff;

	// ****************************************
	// apb read data
	// ****************************************
	reg [31:0] rdata_mux;
	always @* begin
		rdata_mux = 32'h0000_0000;
		if (hit_ctrl) begin
			rdata_mux[`PFC_B_RD] = rd_ff;
			rdata_mux[`PFC_B_WR] = wr_ff;
			rdata_mux[`PFC_B_ERASE] = erase_sel_ff;
			rdata_mux[`PFC_B_LATCH] = latch_sel_ff;
			rdata_mux[`PFC_B_MODIFY] = modify_ff;
			rdata_mux[`PFC_B_REGION] = region_ff;
			rdata_mux[`PFC_B_FAULT] = fault_ff;
			rdata_mux[`PFC_B_DONE] = done_ff;
			rdata_mux[`PFC_B_IRQEN] = irq_en_ff;
			rdata_mux[`PFC_B_BUSY] = !idle;
		end else if (hit_addr) begin
			rdata_mux[14:0] = addr_ff;
		end else if (hit_data) begin
			rdata_mux[13:0] = data_ff;
		end
	end
	assign prdata = (acc && !pwrite) ? rdata_mux : 32'h0000_0000;

	// ****************************************
	// unlock key tracker
	// ****************************************
	// any other bus access between the steps disarms the sequence
	always @* begin
		nxt_key = key_ff;
		if (unlock_break) begin
			nxt_key = KY_NONE;
		end else if (acc) begin
			if (wr_acc && hit_key && pwdata[7:0] == `PFC_KEY1) begin
				nxt_key = KY_ONE;
			end else if (wr_acc && hit_key && pwdata[7:0] == `PFC_KEY2 && key_ff == KY_ONE) begin
				nxt_key = KY_ARMED;
			end else begin
				nxt_key = KY_NONE;
			end
		end
	end

	wire key_broken = (key_ff != KY_NONE) && (unlock_break ||
		(acc && !(wr_acc && (hit_key || hit_ctrl))));
	wire go = trig_wr && key_ff == KY_ARMED && !unlock_break && modify_ff;
	wire go_erase = go && erase_sel_ff;
	wire go_load = go && !erase_sel_ff && latch_sel_ff;
	wire go_prog = go && !erase_sel_ff && !latch_sel_ff;
	wire go_bad = (go_erase || go_prog) && protect;

	// ****************************************
	// sequencer
	// ****************************************
	always @* begin
		nxt_state = state_ff;
		latch_clear = 1'b0;
		latch_load = go_load; // latch loads ignore protection
		case (state_ff)
			ST_IDLE: begin
				if (ind_req && !ind_store && (ind_ptr[15] || win_hit(ind_ptr))) begin
					nxt_state = ST_IND;
				end else if (trig_rd) begin
					nxt_state = ST_RD;
				end else if (go_erase && !go_bad) begin
					nxt_state = ST_ERASE;
				end else if (go_prog && !go_bad) begin
					nxt_state = ST_PROG;
				end
			end
			ST_RD: nxt_state = ST_IDLE;
			ST_IND: nxt_state = ST_IDLE;
			ST_ERASE: nxt_state = ST_WAIT;
			ST_PROG: nxt_state = ST_WAIT;
			ST_WAIT: begin
				if (!fl_busy && !fl_erase_ff && !fl_prog_ff) begin
					if (erase_sel_ff) begin
						nxt_state = ST_IDLE;
					end else if (idx_ff == `PFC_LAST_LATCH) begin
						nxt_state = ST_IDLE;
						latch_clear = 1'b1;
					end else begin
						nxt_state = ST_PROG;
					end
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	wire op_end = (state_ff == ST_WAIT) && (nxt_state == ST_IDLE);

	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= ST_IDLE;
			key_ff <= KY_NONE;
			idx_ff <= 5'h00;
			fl_addr_ff <= 16'h0000;
			fl_rd_ff <= 1'b0;
			fl_erase_ff <= 1'b0;
			fl_prog_ff <= 1'b0;
			fl_wdata_ff <= `PFC_BLANK;
			ind_data_ff <= 8'h00;
			ind_done_ff <= 1'b0;
			ind_win_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			key_ff <= nxt_key;
			fl_rd_ff <= 1'b0;
			fl_erase_ff <= 1'b0;
			fl_prog_ff <= 1'b0;
			ind_done_ff <= 1'b0;
			if (idle && nxt_state == ST_IND) begin
				fl_addr_ff <= {1'b0, ind_ptr[14:0]};
				fl_rd_ff <= !win_hit(ind_ptr);
				ind_win_ff <= win_hit(ind_ptr);
			end else if (idle && nxt_state == ST_RD) begin
				fl_addr_ff <= {pwdata[`PFC_B_REGION], addr_ff};
				fl_rd_ff <= 1'b1;
			end else if (idle && nxt_state == ST_ERASE) begin
				fl_addr_ff <= {region_ff, row, 5'h00};
				fl_erase_ff <= 1'b1;
			end
			if (state_ff == ST_IND) begin
				ind_data_ff <= ind_win_ff ? 8'h00 : fl_rdata[7:0];
				ind_done_ff <= 1'b1;
			end
			if (idle) begin
				idx_ff <= 5'h00;
			end else if (state_ff == ST_WAIT && nxt_state == ST_PROG) begin
				idx_ff <= idx_ff + 5'h01;
			end
			if (nxt_state == ST_PROG) begin
				// no erase step is issued before programming
				fl_addr_ff <= {region_ff, row, (idle ? 5'h00 : idx_ff + 5'h01)};
				fl_wdata_ff <= latch_ff[idle ? 5'h00 : idx_ff + 5'h01];
				fl_prog_ff <= 1'b1;
			end
		end
	end

	// ****************************************
	// software registers
	// ****************************************
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rd_ff <= 1'b0;
			wr_ff <= 1'b0;
			erase_sel_ff <= 1'b0;
			latch_sel_ff <= 1'b0;
			modify_ff <= 1'b0;
			region_ff <= 1'b0;
			fault_ff <= 1'b0;
			done_ff <= 1'b0;
			irq_en_ff <= 1'b0;
			addr_ff <= `PFC_ADDR_RST;
			data_ff <= `PFC_DATA_RST;
			boot_ff <= 1'b1;
		end else begin
			boot_ff <= 1'b0;
			if (sw_ctrl) begin
				erase_sel_ff <= pwdata[`PFC_B_ERASE];
				latch_sel_ff <= pwdata[`PFC_B_LATCH];
				modify_ff <= pwdata[`PFC_B_MODIFY];
				region_ff <= pwdata[`PFC_B_REGION];
				irq_en_ff <= pwdata[`PFC_B_IRQEN];
				rd_ff <= trig_rd;
				wr_ff <= go && !go_load && !go_bad;
			end else if (state_ff == ST_RD) begin
				rd_ff <= 1'b0;
			end else if (op_end) begin
				wr_ff <= 1'b0;
			end
			// hardware set wins over a software clear
			if ((boot_ff && abort_seen) || go_bad || key_broken) begin
				fault_ff <= 1'b1;
			end else if (sw_ctrl) begin
				fault_ff <= pwdata[`PFC_B_FAULT];
			end
			if (op_end) begin
				done_ff <= 1'b1;
			end else if (sw_ctrl) begin
				done_ff <= pwdata[`PFC_B_DONE];
			end
			if (wr_acc && hit_addr && idle) begin
				addr_ff <= pwdata[14:0];
			end
			if (state_ff == ST_RD) begin
				if (region_ff && !cfg_readable(addr_ff)) begin
					data_ff <= 14'h0000;
				end else begin
					data_ff <= fl_rdata;
				end
			end else if (wr_acc && hit_data && idle) begin
				data_ff <= pwdata[13:0];
			end
		end
	end

	// ****************************************
	// write latches
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < `PFC_LATCHES; gi = gi + 1) begin : g_latch
			always @(posedge clock or negedge reset_n) begin
				if (!reset_n) begin
					latch_ff[gi] <= `PFC_BLANK;
				end else if (latch_clear) begin
					latch_ff[gi] <= `PFC_BLANK;
				end else if (latch_load && addr_ff[4:0] == gi) begin
					latch_ff[gi] <= data_ff;
				end
			end
		end
	endgenerate

endmodule // pfc_ctrl

// >>> dv/pfc_flash_model.sv
// flash array model standing behind the controller
`timescale 1ns/1ns
module pfc_flash_model (
	input wire clock, // controller clock
	input wire reset_n, // async reset, active low
	input wire slow, // stretch the busy time
	input wire [15:0] addr, // region and word address
	input wire rd, // read pulse
	input wire erase, // row erase pulse
	input wire prog, // word program pulse
	input wire [13:0] wdata, // program data
	output reg [13:0] rdata_ff, // read word
	output wire busy // timer running
);
	reg [13:0] mem [0:65535];
	reg [2:0] cnt_ff;
	integer i;
	initial for (i = 0; i < 65536; i = i + 1) mem[i] = 14'h3fff;
	assign busy = cnt_ff != 3'h0;
	// read word only while the read pulse stands, inverted otherwise
	always @* rdata_ff = rd ? mem[addr] : ~mem[addr];
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cnt_ff <= 3'h0;
		end else begin
			cnt_ff <= (erase | prog) ? (slow ? 3'h4 : 3'h1) : cnt_ff - {2'h0, busy};
			if (erase)
				for (i = 0; i < 32; i = i + 1) mem[{addr[15:5], i[4:0]}] <= 14'h3fff;
			if (prog)
				mem[addr] <= mem[addr] & wdata;
		end
	end
endmodule // pfc_flash_model

// >>> dv/pfc_ctrl_assertions.sv
// port checks for the program flash access controller
`timescale 1ns/1ns
`include "pfc_consts.vh"
module pfc_ctrl_assertions (
	input wire clock, // clock
	input wire reset_n, // reset, active low
	input wire psel, // apb select
	input wire penable, // apb access
	input wire pwrite, // apb direction
	input wire [11:0] paddr, // apb address
	input wire [31:0] pwdata, // apb write data
	input wire ind_req, // indirect request
	input wire ind_store, // indirect store
	input wire [15:0] ind_ptr, // pointer pair
	input wire [7:0] ind_data_ff, // indirect byte
	input wire ind_done_ff, // indirect answer
	input wire cpu_stall, // cpu hold
	input wire pfm_protect, // write protect
	input wire [15:0] fl_addr_ff, // flash address
	input wire fl_rd_ff, // flash read
	input wire fl_erase_ff, // flash erase
	input wire fl_prog_ff, // flash program
	input wire fl_busy // flash busy
);
	reg [5:0] pcnt_ff;
	wire kick = psel && penable && pwrite && paddr == `PFC_OFF_CTRL && !cpu_stall;
	wire ask = ind_req && !cpu_stall;
	// counts program pulses within one stalled operation
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			pcnt_ff <= 6'h00;
		else
			pcnt_ff <= cpu_stall ? pcnt_ff + {5'h00, fl_prog_ff} : 6'h00;
	end
	default clocking dc @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	read_kick_a: assert property (kick && pwdata[0] |=> fl_rd_ff && cpu_stall)
		else $error("read trigger gave no flash read");
	ind_read_a: assert property (ask && !ind_store && ind_ptr[15] |=> cpu_stall ##1 ind_done_ff)
		else $error("indirect read not answered");
	window_zero_a: assert property (ask && !ind_store && ind_ptr[15:1] == 15'h0000
		|-> ##[1:2] ind_done_ff && ind_data_ff == 8'h00) else $error("window read not zero");
	store_none_a: assert property (ask && ind_store |=> !cpu_stall && !fl_prog_ff && !fl_erase_ff)
		else $error("indirect store acted");
	done_pulse_a: assert property (ind_done_ff |=> !ind_done_ff)
		else $error("indirect answer too long");
	busy_stall_a: assert property (fl_busy || fl_erase_ff || fl_prog_ff |-> cpu_stall)
		else $error("cpu ran during flash operation");
	erase_row_a: assert property (fl_erase_ff |-> fl_addr_ff[4:0] == 5'h00 && !fl_prog_ff)
		else $error("erase not row aligned");
	prog_seq_a: assert property (fl_prog_ff |-> fl_addr_ff[4:0] == pcnt_ff[4:0] && pcnt_ff < 6'h20)
		else $error("program word out of sequence");
	protect_a: assert property ((fl_erase_ff || fl_prog_ff) && !fl_addr_ff[15] |-> !pfm_protect)
		else $error("protected flash modified");
endmodule // pfc_ctrl_assertions

// >>> dv/testbench.sv
// self-checking bench for the program flash access controller
`timescale 1ns/1ns
`include "pfc_consts.vh"
module testbench;
	reg clock = 1'h0, reset_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	reg ind_req = 1'h0, ind_store = 1'h0, unlock_break = 1'h0, pfm_protect = 1'h0;
	reg abort_seen = 1'h0, slow = 1'h0, er;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h0000_0000, r, seed = 32'h0000_f42f;
	reg [15:0] ind_ptr = 16'h0000;
	reg [13:0] d [0:2];
	reg [15:0] ad [0:2];
	wire [31:0] prdata;
	wire pready, pslverr, cpu_stall, fl_rd_ff, fl_erase_ff, fl_prog_ff, fl_busy, irq, ind_done_ff;
	wire [7:0] ind_data_ff;
	wire [15:0] fl_addr_ff;
	wire [13:0] fl_wdata_ff, fl_rdata;
	integer bad_count = 0, compares = 0, i;
	always #5 clock = ~clock;
	pfc_ctrl dut_u (.*);
	pfc_flash_model fm_u (.clock(clock), .reset_n(reset_n), .slow(slow), .addr(fl_addr_ff),
		.rd(fl_rd_ff), .erase(fl_erase_ff), .prog(fl_prog_ff), .wdata(fl_wdata_ff),
		.rdata_ff(fl_rdata), .busy(fl_busy));
	function [31:0] xs(input [31:0] v);
		begin
			xs = v ^ (v << 13);
			xs = xs ^ (xs >> 17);
			xs = xs ^ (xs << 5);
		end
	endfunction
	task chk(input [31:0] g, input [31:0] e);
		begin
			compares = compares + 1;
			if (g !== e) begin
				bad_count = bad_count + 1;
				$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
			end
		end
	endtask
	task acc(input w, input [11:0] a, input [31:0] v);
		begin
			psel <= 1'h1;
			pwrite <= w;
			paddr <= a;
			pwdata <= v;
			@(posedge clock);
			penable <= 1'h1;
			do @(posedge clock); while (pready !== 1'h1);
			r = prdata;
			er = pslverr;
			psel <= 1'h0;
			penable <= 1'h0;
			@(posedge clock);
		end
	endtask
	task idle;
		do @(posedge clock); while (cpu_stall !== 1'h0);
	endtask
	task ul(input [31:0] c, input b);
		begin
			acc(1'h1, `PFC_OFF_CTRL, c);
			acc(1'h1, `PFC_OFF_KEY, {24'h0, `PFC_KEY1});
			unlock_break <= b;
			@(posedge clock);
			unlock_break <= 1'h0;
			acc(1'h1, `PFC_OFF_KEY, {24'h0, `PFC_KEY2});
			acc(1'h1, `PFC_OFF_CTRL, c | 32'h0000_0002);
			idle;
		end
	endtask
	task rdw(input [15:0] a);
		begin
			acc(1'h1, `PFC_OFF_ADDR, {17'h0, a[14:0]});
			acc(1'h1, `PFC_OFF_CTRL, {26'h0, a[15], 5'h01});
			idle;
			acc(1'h0, `PFC_OFF_DATA, 32'h0000_0000);
		end
	endtask
	task ind(input [15:0] p, input s);
		begin
			ind_ptr <= p;
			ind_store <= s;
			ind_req <= 1'h1;
			@(posedge clock);
			ind_req <= 1'h0;
			repeat (2) @(posedge clock);
		end
	endtask
	task complete_run;
		begin
			if (bad_count == 0 && compares > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	initial begin
		#300000;
		bad_count = bad_count + 1;
		complete_run;
	end
	initial begin
		repeat (3) @(posedge clock);
		reset_n <= 1'h1;
		@(posedge clock);
		acc(1'h0, `PFC_OFF_CTRL, 32'h0000_0000);
		chk(r, 32'h0000_0000);
		acc(1'h0, 12'h010, 32'h0000_0000);
		chk({er, r}, 33'h0_0000_0000 | 33'h1_0000_0000);
		for (i = 0; i < 3; i = i + 1) begin
			seed = xs(seed);
			d[i] = seed[13:0];
			ad[i] = (i == 2) ? 16'h005f : 16'h0040 + 7 * i;
			acc(1'h1, `PFC_OFF_ADDR, {16'h0, ad[i]});
			acc(1'h1, `PFC_OFF_DATA, {18'h0, d[i]});
			ul(32'h0000_0018, 1'h0);
		end
		ul(32'h0000_0010, 1'h0);
		for (i = 0; i < 3; i = i + 1) begin
			rdw(ad[i]);
			chk(r, {18'h0, d[i]});
		end
		rdw(16'h0041);
		chk(r, 32'h0000_3fff);
		acc(1'h1, `PFC_OFF_ADDR, 32'h0000_0080);
		ul(32'h0000_0010, 1'h0);
		rdw(16'h0080);
		chk(r, 32'h0000_3fff);
		acc(1'h1, `PFC_OFF_DATA, {18'h0, d[1]});
		acc(1'h0, `PFC_OFF_DATA, 32'h0000_0000);
		chk(r, {18'h0, d[1]});
		rdw(16'h8004);
		chk(r, 32'h0000_0000);
		acc(1'h1, `PFC_OFF_ADDR, 32'h0000_0040);
		ul(32'h0000_0014, 1'h1);
		ul(32'h0000_0004, 1'h0);
		pfm_protect <= 1'h1;
		ul(32'h0000_0014, 1'h0);
		acc(1'h0, `PFC_OFF_CTRL, 32'h0000_0000);
		chk(r & 32'h0000_007e, 32'h0000_0054);
		pfm_protect <= 1'h0;
		rdw(ad[0]);
		chk(r, {18'h0, d[0]});
		acc(1'h1, `PFC_OFF_DATA, {18'h0, d[2]});
		acc(1'h1, `PFC_OFF_ADDR, 32'h0000_0080);
		ul(32'h0000_0018, 1'h0);
		acc(1'h1, `PFC_OFF_ADDR, 32'h0000_0040);
		slow <= 1'h1;
		ul(32'h0000_0114, 1'h0);
		acc(1'h0, `PFC_OFF_CTRL, 32'h0000_0000);
		chk(r, 32'h0000_0194);
		chk(irq, 1'h1);
		acc(1'h1, `PFC_OFF_CTRL, 32'h0000_0100);
		chk(irq, 1'h0);
		rdw(ad[2]);
		chk(r, 32'h0000_3fff);
		acc(1'h1, `PFC_OFF_ADDR, 32'h0000_0080);
		ul(32'h0000_0010, 1'h0);
		rdw(16'h0080);
		chk(r, {18'h0, d[2]});
		ind(16'h8080, 1'h0);
		chk(ind_data_ff, d[2][7:0]);
		ind(`PFC_WIN1, 1'h0);
		chk(ind_data_ff, 8'h00);
		ind(16'h8080, 1'h1);
		rdw(16'h0080);
		chk(r, {18'h0, d[2]});
		complete_run;
	end
endmodule // testbench
bind pfc_ctrl pfc_ctrl_assertions chk_u (.*);
